// File: bipolar_receive_line_decoder.sv
// Receive bipolar line decoder with violation, zero and signal-lost monitoring
//
// Local design decision: the address-and-strobe port.
module bipolar_receive_line_decoder
  import rx_line_pkg::*;
#(
  parameter int LOST_ZEROS = LOST_ZEROS_DEFAULT,
  parameter int LOST_W = 8
)
(
  input wire logic clock_in,
  input wire logic rstn_in,
  input wire logic rail_pos_in,
  input wire logic rail_neg_in,
  input wire logic perf_monitor_update_in,
  input wire logic port_interrupt_enable_field_in,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic [DATA_W-1:0] wr_data_in,
  input wire logic wr_strobe_in,
  input wire logic rd_strobe_in,
  output logic [DATA_W-1:0] rd_data_out,
  output logic decoded_data_out,
  output logic port_irq_out
);

  localparam logic [LOST_W-1:0] LOST_LIMIT = LOST_W'(LOST_ZEROS);

  function automatic logic sig_match(input logic [2:0] zrun, input logic hdb3,
                                     input logic fmt, input logic first,
                                     input logic pol, input logic prev_pol);
    logic enough;
    enough = zrun >= (hdb3 ? SIG_ZEROS_HDB3 : SIG_ZEROS_B3ZS);
    return enough && (first || !fmt || (pol != prev_pol));
  endfunction

  function automatic logic [15:0] sat_inc(input logic [15:0] v, input logic inc);
    return (inc && v != 16'hFFFF) ? v + 16'h0001 : v;
  endfunction

  // Three-stage rail synchroniser, the first stage feeds only the second
  logic [1:0] s1_r, s2_r, s3_r, filt_r;
  logic [1:0] s1_nxt, s2_nxt, s3_nxt, filt_nxt;

  always_comb
  begin
    s1_nxt = {rail_pos_in, rail_neg_in};
    s2_nxt = s1_r;
    s3_nxt = s2_r;
  end

  // Each rail holds a mark for one slot only, so a two-stage agree filter would eat every mark
  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : g_filt
      assign filt_nxt[g] = s3_r[g];
    end
  endgenerate

  always_ff @(posedge clock_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      s1_r <= 2'h0;
      s2_r <= 2'h0;
      s3_r <= 2'h0;
      filt_r <= 2'h0;
    end
    else
    begin
      s1_r <= s1_nxt;
      s2_r <= s2_nxt;
      s3_r <= s3_nxt;
      filt_r <= filt_nxt;
    end
  end

  // Registers
  logic [15:0] ctrl_r, ie_r, vacc_r, xacc_r, vcnt_r, xcnt_r;
  logic [15:0] ctrl_nxt, ie_nxt, vacc_nxt, xacc_nxt, vcnt_nxt, xcnt_nxt;
  logic [LAT_W-1:0] lat_r, lat_nxt, lat_set;
  logic zs_dis, dec_fmt, err_fmt, e3_sel, hdb3;

  assign zs_dis = ctrl_r[CTRL_ZS_DIS];
  assign dec_fmt = ctrl_r[CTRL_DEC_FMT];
  assign err_fmt = ctrl_r[CTRL_ERR_FMT];
  assign e3_sel = ctrl_r[CTRL_E3_SEL];
  assign hdb3 = ctrl_r[CTRL_HDB3];

  // Line state
  logic pulse, pol, raw_viol, line_coding_violation, err_sig, dec_sig, count_evt, xz_evt;
  logic seen_r, last_pol_r, vseen_r, vpol_r, err_first_r, err_pol_r;
  logic dec_first_r, dec_pol_r, lost_r;
  logic seen_nxt, last_pol_nxt, vseen_nxt, vpol_nxt, err_first_nxt, err_pol_nxt;
  logic dec_first_nxt, dec_pol_nxt, lost_nxt;
  logic [2:0] zrun_r, zrun_nxt;
  logic [3:0] pipe_r, pipe_nxt;
  logic [LOST_W-1:0] lost_cnt_r, lost_cnt_nxt;

  // A pulse on both rails at once is taken as a zero
  assign pulse = filt_r[1] ^ filt_r[0];
  assign pol = filt_r[1];
  assign raw_viol = pulse && seen_r && (pol == last_pol_r);
  assign line_coding_violation = raw_viol && vseen_r && (pol == vpol_r);
  assign err_sig = !zs_dis && raw_viol &&
                   sig_match(zrun_r, hdb3, err_fmt, err_first_r, pol, err_pol_r);
  assign dec_sig = !zs_dis && raw_viol &&
                   sig_match(zrun_r, hdb3, dec_fmt, dec_first_r, pol, dec_pol_r);
  assign count_evt = (hdb3 && e3_sel) ? line_coding_violation : (raw_viol && !err_sig);
  assign xz_evt = !pulse &&
                  ((zrun_r + 3'h1) == (hdb3 ? XZ_RUN_HDB3 : XZ_RUN_B3ZS));

  always_comb
  begin
    seen_nxt = seen_r || pulse;
    last_pol_nxt = pulse ? pol : last_pol_r;
    vseen_nxt = vseen_r || raw_viol;
    vpol_nxt = raw_viol ? pol : vpol_r;
    err_first_nxt = err_first_r && !err_sig;
    err_pol_nxt = err_sig ? pol : err_pol_r;
    dec_first_nxt = dec_first_r && !dec_sig;
    dec_pol_nxt = dec_sig ? pol : dec_pol_r;
    zrun_nxt = pulse ? 3'h0 : ((zrun_r == 3'h7) ? zrun_r : zrun_r + 3'h1);
    // Substituted marks are still in the delay line when the violation arrives
    pipe_nxt = {pipe_r[2:0], pulse};
    if (dec_sig)
    begin
      if (hdb3)
      begin
        pipe_nxt = 4'h0;
      end
      else
      begin
        pipe_nxt[2:0] = 3'h0;
      end
    end
    if (zs_dis)
    begin
      lost_cnt_nxt = '0;
      lost_nxt = 1'b0;
    end
    else if (pulse)
    begin
      lost_cnt_nxt = '0;
      lost_nxt = 1'b0;
    end
    else
    begin
      lost_cnt_nxt = (lost_cnt_r == LOST_LIMIT) ? lost_cnt_r : lost_cnt_r + 1'b1;
      lost_nxt = lost_r || (lost_cnt_nxt == LOST_LIMIT);
    end
  end

  always_ff @(posedge clock_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      seen_r <= 1'b0;
      last_pol_r <= 1'b0;
      vseen_r <= 1'b0;
      vpol_r <= 1'b0;
      err_first_r <= 1'b1;
      err_pol_r <= 1'b0;
      dec_first_r <= 1'b1;
      dec_pol_r <= 1'b0;
      zrun_r <= 3'h0;
      pipe_r <= 4'h0;
      lost_cnt_r <= '0;
      lost_r <= 1'b0;
    end
    else
    begin
      seen_r <= seen_nxt;
      last_pol_r <= last_pol_nxt;
      vseen_r <= vseen_nxt;
      vpol_r <= vpol_nxt;
      err_first_r <= err_first_nxt;
      err_pol_r <= err_pol_nxt;
      dec_first_r <= dec_first_nxt;
      dec_pol_r <= dec_pol_nxt;
      zrun_r <= zrun_nxt;
      pipe_r <= pipe_nxt;
      lost_cnt_r <= lost_cnt_nxt;
      lost_r <= lost_nxt;
    end
  end

  // Register file, counters and flags
  logic wr_ctrl, wr_ie, wr_lat, perf_monitor_update;
  logic [DATA_W-1:0] rd_nxt, rd_mux;
  logic irq_nxt, dec_nxt;

  assign perf_monitor_update = perf_monitor_update_in;
  assign wr_ctrl = wr_strobe_in && (addr_in == OFF_CTRL);
  assign wr_ie = wr_strobe_in && (addr_in == OFF_IE);
  assign wr_lat = wr_strobe_in && (addr_in == OFF_LATCH);

  always_comb
  begin
    ctrl_nxt = wr_ctrl ? (wr_data_in & CTRL_MASK) : ctrl_r;
    ie_nxt = wr_ie ? {10'h000, wr_data_in[LAT_W-1:0]} : ie_r;
    // Copying in this cycle's event keeps it from falling between intervals
    if (perf_monitor_update)
    begin
      vcnt_nxt = sat_inc(vacc_r, count_evt);
      xcnt_nxt = sat_inc(xacc_r, xz_evt);
      vacc_nxt = 16'h0000;
      xacc_nxt = 16'h0000;
    end
    else
    begin
      vcnt_nxt = vcnt_r;
      xcnt_nxt = xcnt_r;
      vacc_nxt = sat_inc(vacc_r, count_evt);
      xacc_nxt = sat_inc(xacc_r, xz_evt);
    end
    lat_set = '0;
    lat_set[LAT_LOST] = lost_nxt != lost_r;
    lat_set[LAT_VCNT] = (vcnt_r == 16'h0000) && (vcnt_nxt != 16'h0000);
    lat_set[LAT_VEVT] = count_evt;
    lat_set[LAT_XCNT] = (xcnt_r == 16'h0000) && (xcnt_nxt != 16'h0000);
    lat_set[LAT_XEVT] = xz_evt;
    lat_set[LAT_SIG] = dec_sig;
    // A new event in the clearing cycle survives the clear
    lat_nxt = (lat_r & ~(wr_lat ? wr_data_in[LAT_W-1:0] : 6'h00)) | lat_set;
    irq_nxt = port_interrupt_enable_field_in && |(lat_r & ie_r[LAT_W-1:0]);
    dec_nxt = pipe_r[3];
    rd_mux = 16'h0000;
    if (addr_in == OFF_CTRL)
    begin
      rd_mux = ctrl_r;
    end
    else if (addr_in == OFF_STAT)
    begin
      rd_mux[STAT_LOST] = lost_r;
      rd_mux[STAT_VNZ] = vcnt_r != 16'h0000;
      rd_mux[STAT_XNZ] = xcnt_r != 16'h0000;
    end
    else if (addr_in == OFF_LATCH)
    begin
      rd_mux = {10'h000, lat_r};
    end
    else if (addr_in == OFF_IE)
    begin
      rd_mux = ie_r;
    end
    else if (addr_in == OFF_VCNT)
    begin
      rd_mux = vcnt_r;
    end
    else if (addr_in == OFF_XCNT)
    begin
      rd_mux = xcnt_r;
    end
    rd_nxt = rd_strobe_in ? rd_mux : 16'h0000;
  end

  always_ff @(posedge clock_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      ctrl_r <= CTRL_RESET;
      ie_r <= IE_RESET;
      vacc_r <= CNT_RESET;
      xacc_r <= CNT_RESET;
      vcnt_r <= CNT_RESET;
      xcnt_r <= CNT_RESET;
      lat_r <= LAT_RESET;
      rd_data_out <= 16'h0000;
      port_irq_out <= 1'b0;
      decoded_data_out <= 1'b0;
    end
    else
    begin
      ctrl_r <= ctrl_nxt;
      ie_r <= ie_nxt;
      vacc_r <= vacc_nxt;
      xacc_r <= xacc_nxt;
      vcnt_r <= vcnt_nxt;
      xcnt_r <= xcnt_nxt;
      lat_r <= lat_nxt;
      rd_data_out <= rd_nxt;
      port_irq_out <= irq_nxt;
      decoded_data_out <= dec_nxt;
    end
  end

  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!rstn_in);

  a_lost_held_clear: assert property (zs_dis |=> !lost_r)
    else $error("signal lost set while decoding disabled");
  a_status_nonzero: assert property (rd_strobe_in && addr_in == OFF_STAT |=>
      rd_data_out[STAT_VNZ] == ($past(vcnt_r) != 16'h0000) &&
      rd_data_out[STAT_XNZ] == ($past(xcnt_r) != 16'h0000))
    else $error("status nonzero bits wrong");
  a_count_rise_flag: assert property ($rose(vcnt_r != 16'h0000) |-> lat_r[LAT_VCNT])
    else $error("count flag not set on rise");
  a_lost_change_flag: assert property ($changed(lost_r) |-> lat_r[LAT_LOST])
    else $error("signal lost change not latched");
  a_irq_port_gate: assert property (!port_interrupt_enable_field_in |=> !port_irq_out)
    else $error("interrupt without port enable");
  a_count_only_update: assert property (!perf_monitor_update |=> $stable(vcnt_r) && $stable(xcnt_r))
    else $error("counter changed without update");
  a_acc_restart: assert property (perf_monitor_update |=> vacc_r == 16'h0000 && xacc_r == 16'h0000)
    else $error("accumulator not restarted");
  a_viol_flag_set: assert property (count_evt |=> lat_r[LAT_VEVT])
    else $error("violation flag not set");
  a_sig_flag_set: assert property (dec_sig |=> lat_r[LAT_SIG])
    else $error("signature flag not set");
  a_b3zs_no_e3: assert property (!hdb3 && raw_viol && !err_sig |-> count_evt)
    else $error("B3ZS mode did not count violation");
  a_excess_b3zs: assert property (!hdb3 && !pulse && zrun_r == 3'h2 |=> lat_r[LAT_XEVT])
    else $error("three zeros not flagged");
  a_flag_sticky: assert property (lat_r[LAT_SIG] && !wr_lat |=> lat_r[LAT_SIG])
    else $error("latched flag dropped without clear");
  a_first_sig: assert property (dec_first_r && raw_viol && !zs_dis &&
      zrun_r >= SIG_ZEROS_HDB3 |-> dec_sig)
    else $error("first signature missed");

endmodule

// File: rx_line_pkg.sv
// Constants shared by the receive bipolar line decoder
package rx_line_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam logic [7:0] OFF_CTRL = 8'h90;
  localparam logic [7:0] OFF_STAT = 8'h94;
  localparam logic [7:0] OFF_LATCH = 8'h96;
  localparam logic [7:0] OFF_IE = 8'h98;
  localparam logic [7:0] OFF_VCNT = 8'h9C;
  localparam logic [7:0] OFF_XCNT = 8'h9E;
  localparam int CTRL_ZS_DIS = 0;
  localparam int CTRL_DEC_FMT = 1;
  localparam int CTRL_ERR_FMT = 2;
  localparam int CTRL_E3_SEL = 3;
  localparam int CTRL_HDB3 = 8;
  localparam logic [15:0] CTRL_MASK = 16'h010F;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [15:0] IE_RESET = 16'h0000;
  localparam logic [15:0] CNT_RESET = 16'h0000;
  localparam int STAT_LOST = 0;
  localparam int STAT_VNZ = 1;
  localparam int STAT_XNZ = 3;
  localparam int LAT_LOST = 0;
  localparam int LAT_VCNT = 1;
  localparam int LAT_VEVT = 2;
  localparam int LAT_XCNT = 3;
  localparam int LAT_XEVT = 4;
  localparam int LAT_SIG = 5;
  localparam int LAT_W = 6;
  localparam logic [5:0] LAT_RESET = 6'h00;
  localparam logic [2:0] SIG_ZEROS_B3ZS = 3'h1;
  localparam logic [2:0] SIG_ZEROS_HDB3 = 3'h2;
  localparam logic [2:0] XZ_RUN_B3ZS = 3'h3;
  localparam logic [2:0] XZ_RUN_HDB3 = 3'h4;
  localparam int LOST_ZEROS_DEFAULT = 32;
endpackage

// File: line_model.sv
// Line interface receiver model feeding bipolar rails one symbol per clock
module line_model
(
  input wire logic clock_in,
  output logic rail_pos_out,
  output logic rail_neg_out
);
  timeunit 1ns;
  timeprecision 1ns;
  int q[$];
  int last_pol = -1;
  bit idle_zero = 1'b1;
  initial
  begin
    rail_pos_out = 1'b0;
    rail_neg_out = 1'b0;
  end
  // Between bursts the line idles on alternating marks, or on spaces to mimic a dead line
  always @(posedge clock_in)
  begin
    int s;
    s = (q.size() > 0) ? q.pop_front() : (idle_zero ? 0 : -last_pol);
    rail_pos_out <= (s > 0);
    rail_neg_out <= (s < 0);
    if (s != 0)
      last_pol = s;
  end
  // Pushing at the falling edge keeps the polarity choice clear of the popping edge
  task automatic code(input int n0, input int p);
    @(negedge clock_in);
    if (last_pol != p)
      q.push_back(p);
    repeat (n0) q.push_back(0);
    q.push_back(p);
    while (q.size() > 0) @(posedge clock_in);
    repeat (10) @(posedge clock_in);
  endtask
  task automatic zeros(input int n);
    @(negedge clock_in);
    repeat (n) q.push_back(0);
    while (q.size() > 0) @(posedge clock_in);
    repeat (10) @(posedge clock_in);
  endtask
endmodule

// File: tb_bipolar_receive_line_decoder.sv
// Register level testbench for the receive bipolar line decoder
module tb_bipolar_receive_line_decoder;
  import rx_line_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock_in, rstn_in, rail_pos, rail_neg, perf_monitor_update, pen, wr, rd, decoded, irq;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata, rdata;
  int fails = 0;
  int tests_run = 0;
  int lv, sp, p;
  bipolar_receive_line_decoder #(.LOST_ZEROS(4)) bipolar_receive_line_decoder_inst (
    .clock_in(clock_in), .rstn_in(rstn_in), .rail_pos_in(rail_pos), .rail_neg_in(rail_neg),
    .perf_monitor_update_in(perf_monitor_update), .port_interrupt_enable_field_in(pen), .addr_in(addr),
    .wr_data_in(wdata), .wr_strobe_in(wr), .rd_strobe_in(rd), .rd_data_out(rdata),
    .decoded_data_out(decoded), .port_irq_out(irq));
  line_model line_model_inst (.clock_in(clock_in), .rail_pos_out(rail_pos),
    .rail_neg_out(rail_neg));
  initial
  begin
    clock_in = 1'b0;
    forever #25 clock_in = ~clock_in;
  end
  task automatic end_sim;
    $display("Checks %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      fails++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    @(posedge clock_in);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clock_in);
    wr <= 1'b0;
  endtask
  // Read data is only valid in the single cycle after the strobe edge
  task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
    @(posedge clock_in);
    rd <= 1'b1;
    addr <= a;
    @(posedge clock_in);
    rd <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask
  task automatic update;
    @(posedge clock_in);
    perf_monitor_update <= 1'b1;
    @(posedge clock_in);
    perf_monitor_update <= 1'b0;
  endtask
  initial
  begin
    rstn_in = 1'b0;
    {perf_monitor_update, pen, wr, rd} = 4'h0;
    addr = 8'h00;
    wdata = 16'h0000;
    repeat (8) @(posedge clock_in);
    rstn_in <= 1'b1;
    repeat (12) @(posedge clock_in);
    rd_chk(OFF_STAT, 16'h0001);
    rd_chk(OFF_LATCH, 16'h0011);
    rd_chk(OFF_CTRL, 16'h0000);
    rd_chk(OFF_IE, 16'h0000);
    rd_chk(OFF_VCNT, 16'h0000);
    rd_chk(OFF_XCNT, 16'h0000);
    rd_chk(8'h92, 16'h0000);
    wr_reg(OFF_CTRL, 16'hFFFF);
    rd_chk(OFF_CTRL, 16'h010F);
    rd_chk(OFF_STAT, 16'h0000);
    wr_reg(OFF_CTRL, 16'h0000);
    wr_reg(OFF_STAT, 16'hFFFF);
    repeat (2) @(posedge clock_in);
    rd_chk(OFF_STAT, 16'h0001);
    wr_reg(OFF_IE, 16'hFFFF);
    rd_chk(OFF_IE, 16'h003F);
    wr_reg(OFF_IE, 16'h0000);
    line_model_inst.idle_zero = 1'b0;
    repeat (12) @(posedge clock_in);
    #1 chk(decoded, 1'b1);
    update();
    update();
    wr_reg(OFF_LATCH, 16'h003F);
    rd_chk(OFF_STAT, 16'h0000);
    rd_chk(OFF_LATCH, 16'h0000);
    // Plain violation with no space before it
    line_model_inst.code(0, 1);
    lv = 1;
    rd_chk(OFF_LATCH, 16'h0004);
    update();
    rd_chk(OFF_VCNT, 16'h0001);
    rd_chk(OFF_STAT, 16'h0002);
    rd_chk(OFF_LATCH, 16'h0006);
    wr_reg(OFF_LATCH, 16'h003F);
    // First signature after reset is taken whatever its polarity and format
    wr_reg(OFF_CTRL, 16'h0006);
    line_model_inst.code(1, -1);
    sp = -1;
    lv = -1;
    rd_chk(OFF_LATCH, 16'h0020);
    wr_reg(OFF_IE, 16'h0020);
    repeat (3) @(posedge clock_in);
    #1 chk(irq, 1'b0);
    @(posedge clock_in) pen <= 1'b1;
    repeat (3) @(posedge clock_in);
    #1 chk(irq, 1'b1);
    wr_reg(OFF_LATCH, 16'h0020);
    repeat (3) @(posedge clock_in);
    #1 chk(irq, 1'b0);
    update();
    rd_chk(OFF_VCNT, 16'h0000);
    wr_reg(OFF_CTRL, 16'h0006);
    line_model_inst.code(1, sp);
    lv = sp;
    update();
    rd_chk(OFF_VCNT, 16'h0001);
    line_model_inst.code(1, -sp);
    sp = -sp;
    lv = sp;
    update();
    rd_chk(OFF_VCNT, 16'h0000);
    wr_reg(OFF_LATCH, 16'h003F);
    line_model_inst.zeros(3);
    rd_chk(OFF_LATCH, 16'h0010);
    update();
    rd_chk(OFF_XCNT, 16'h0001);
    rd_chk(OFF_STAT, 16'h0008);
    wr_reg(OFF_CTRL, 16'h0100);
    wr_reg(OFF_LATCH, 16'h003F);
    line_model_inst.zeros(3);
    rd_chk(OFF_LATCH, 16'h0000);
    line_model_inst.zeros(4);
    rd_chk(OFF_LATCH, 16'h0011);
    // Format 0 takes an HDB3 signature of the same polarity as the last one
    line_model_inst.code(2, sp);
    rd_chk(OFF_LATCH, 16'h0031);
    // Two violations: the second repeats the first's polarity
    wr_reg(OFF_CTRL, 16'h0108);
    update();
    p = -lv;
    line_model_inst.code(0, p);
    line_model_inst.code(0, p);
    lv = p;
    update();
    rd_chk(OFF_VCNT, 16'h0001);
    wr_reg(OFF_CTRL, 16'h0008);
    update();
    p = -lv;
    line_model_inst.code(0, p);
    line_model_inst.code(0, p);
    update();
    rd_chk(OFF_VCNT, 16'h0002);
    wr_reg(OFF_CTRL, 16'h0001);
    line_model_inst.idle_zero = 1'b1;
    repeat (12) @(posedge clock_in);
    #1 chk(decoded, 1'b0);
    rd_chk(OFF_STAT, 16'h0002);
    end_sim();
  end
  // Whole sequence needs well under 2000 cycles
  initial
  begin
    repeat (20000) @(posedge clock_in);
    fails++;
    end_sim();
  end
endmodule
